// *** rws_map.svh ***
// Constants of the reset and wake sequencer
`ifndef RWS_MAP_SVH
`define RWS_MAP_SVH
`define RWS_CLK_MHZ          40
`define RWS_RESET_VECTOR     16'h0000
`define RWS_PORT_LATCH_RST   8'hff
`define RWS_IDLE_WAKE_CYC    2
`define RWS_SUSP_PREC_NS     400
`define RWS_SUSP_LP_NS       1300
`define RWS_SLEEP_NS         2000
`define RWS_SUSP_PREC_CYC    ((`RWS_SUSP_PREC_NS * `RWS_CLK_MHZ) / 1000)
`define RWS_SUSP_LP_CYC      ((`RWS_SUSP_LP_NS * `RWS_CLK_MHZ) / 1000)
`define RWS_SLEEP_CYC        ((`RWS_SLEEP_NS * `RWS_CLK_MHZ) / 1000)
`define RWS_RELEASE_CYC      4
`define RWS_NUM_SRC          10
`define RWS_SRC_POR          0
`define RWS_SRC_SUPPLY       4
`endif

// *** rws_pkg.sv ***
// Types of the reset and wake sequencer
package rws_pkg;
    typedef enum logic [2:0] {
        RWS_RUN     = 3'b000,
        RWS_IDLE    = 3'b001,
        RWS_SUSPEND = 3'b011,
        RWS_SLEEP   = 3'b010,
        RWS_WAKE    = 3'b110
    } rws_state_t;
    typedef enum logic [1:0] {
        RWS_LP_NORMAL  = 2'b00,
        RWS_LP_IDLE    = 2'b01,
        RWS_LP_SUSPEND = 2'b10,
        RWS_LP_SLEEP   = 2'b11
    } rws_lp_t;
    typedef struct packed {
        logic       core_hold;
        logic       periph_rst;
        logic       irq_timer_off;
        logic       port_od;
        logic       pullup_en;
        logic       wdt_en;
        logic       clk_internal;
        logic [15:0] pc;
    } rws_ctrl_t;
endpackage

// *** rws_sync.sv ***
// Two-flop synchroniser for a bus of levels
`timescale 1ns/1ps
module rws_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         rst,
    // Levels
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule

// *** rws_top.sv ***
// Reset and wake sequencer top
`timescale 1ns/1ps
`include "rws_map.svh"
module rws_top
    import rws_pkg::*;
#(
    parameter int NSRC = `RWS_NUM_SRC
) (
    // Clock and power-on reset
    input  wire logic            clock,
    input  wire logic            rst,
    // Reset causes, asynchronous levels, active high
    input  wire logic [NSRC-1:0] reset_src,
    input  wire logic [NSRC-1:0] reset_src_en,
    // Low-power control
    input  wire logic [1:0]      lp_mode_req,
    input  wire logic            lp_enter,
    input  wire logic            wake_event,
    input  wire logic            osc_low_power,
    // External reset pin drive
    output logic                 external_reset_pin_n_o,
    output logic                 external_reset_pin_n_oe,
    // Core and peripheral control
    output rws_ctrl_t            ctrl,
    output logic                 por_only_rst,
    output logic                 ram_write_block,
    output logic [7:0]           port_latch,
    output logic                 core_run,
    output logic [NSRC-1:0]      reset_cause
);
    logic [NSRC-1:0] src_s;
    logic            wake_s;
    logic            any_src;
    logic            in_reset_reg;
    logic [2:0]      rel_cnt_reg;
    logic            drive_pin_reg;
    rws_state_t      state_reg;
    rws_state_t      state_next;
    logic [6:0]      wake_cnt_reg;

    rws_sync #(.W(NSRC)) u_src_sync (
        .clock (clock),
        .rst   (rst),
        .d     (reset_src),
        .q     (src_s)
    );
    rws_sync #(.W(1)) u_wake_sync (
        .clock (clock),
        .rst   (rst),
        .d     (wake_event),
        .q     (wake_s)
    );

    // Power-on cause is never maskable so a cold start always resets
    assign any_src = |(src_s & (reset_src_en | NSRC'(1)));

    // Release is counted so every enabled source must stay low a few clocks
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            in_reset_reg <= 1'b1;
            rel_cnt_reg  <= 3'h0;
        end else if (any_src) begin
            in_reset_reg <= 1'b1;
            rel_cnt_reg  <= 3'h0;
        end else if (in_reset_reg) begin
            if (rel_cnt_reg == 3'(`RWS_RELEASE_CYC - 1)) begin
                in_reset_reg <= 1'b0;
            end else begin
                rel_cnt_reg <= rel_cnt_reg + 3'h1;
            end
        end
    end

    // Cause capture, latched while in reset
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            reset_cause   <= NSRC'(1);
            drive_pin_reg <= 1'b1;
        end else if (any_src) begin
            reset_cause   <= src_s;
            drive_pin_reg <= drive_pin_reg | src_s[`RWS_SRC_POR] | src_s[`RWS_SRC_SUPPLY];
        end else if (!in_reset_reg) begin
            drive_pin_reg <= 1'b0;
        end
    end

    // Pin is open-drain; it is only ever pulled low
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            external_reset_pin_n_o  <= 1'b0;
            external_reset_pin_n_oe <= 1'b1;
        end else begin
            external_reset_pin_n_o  <= 1'b0;
            external_reset_pin_n_oe <= drive_pin_reg & in_reset_reg;
        end
    end

    // Power-mode state machine
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            RWS_RUN: begin
                if (lp_enter) begin
                    case (lp_mode_req)
                        RWS_LP_IDLE:    state_next = RWS_IDLE;
                        RWS_LP_SUSPEND: state_next = RWS_SUSPEND;
                        RWS_LP_SLEEP:   state_next = RWS_SLEEP;
                        default:        state_next = RWS_RUN;
                    endcase
                end
            end
            RWS_IDLE, RWS_SUSPEND, RWS_SLEEP: begin
                if (wake_s) begin
                    state_next = RWS_WAKE;
                end
            end
            RWS_WAKE: begin
                if (wake_cnt_reg == 7'h0) begin
                    state_next = RWS_RUN;
                end
            end
            default: state_next = RWS_RUN;
        endcase
    end

    // Wake latency loaded from the mode being left
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg    <= RWS_RUN;
            wake_cnt_reg <= 7'h0;
        end else if (in_reset_reg) begin
            state_reg    <= RWS_RUN;
            wake_cnt_reg <= 7'h0;
        end else begin
            state_reg <= state_next;
            if (state_next == RWS_WAKE && state_reg != RWS_WAKE) begin
                case (state_reg)
                    RWS_IDLE:    wake_cnt_reg <= 7'(`RWS_IDLE_WAKE_CYC - 2);
                    RWS_SUSPEND: wake_cnt_reg <= osc_low_power ?
                                 7'(`RWS_SUSP_LP_CYC - 3) : 7'(`RWS_SUSP_PREC_CYC - 3);
                    default:     wake_cnt_reg <= 7'(`RWS_SLEEP_CYC - 3);
                endcase
            end else if (wake_cnt_reg != 7'h0) begin
                wake_cnt_reg <= wake_cnt_reg - 7'h1;
            end
        end
    end

    // Core and peripheral control outputs
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl            <= '{core_hold: 1'b1, periph_rst: 1'b1, irq_timer_off: 1'b1,
                                 port_od: 1'b1, pullup_en: 1'b1, wdt_en: 1'b0,
                                 clk_internal: 1'b1, pc: `RWS_RESET_VECTOR};
            por_only_rst    <= 1'b1;
            ram_write_block <= 1'b1;
            port_latch      <= `RWS_PORT_LATCH_RST;
            core_run        <= 1'b0;
        end else begin
            ctrl.core_hold     <= in_reset_reg;
            ctrl.periph_rst    <= in_reset_reg;
            ctrl.irq_timer_off <= in_reset_reg;
            ctrl.port_od       <= in_reset_reg ? 1'b1 : ctrl.port_od;
            ctrl.pullup_en     <= 1'b1;
            ctrl.wdt_en        <= ~in_reset_reg;
            ctrl.clk_internal  <= 1'b1;
            ctrl.pc            <= `RWS_RESET_VECTOR;
            por_only_rst       <= in_reset_reg & src_s[`RWS_SRC_POR];
            ram_write_block    <= in_reset_reg;
            port_latch         <= in_reset_reg ? `RWS_PORT_LATCH_RST : port_latch;
            core_run           <= ~in_reset_reg & (state_next == RWS_RUN);
        end
    end

    // Assertions
    property p_hold_in_reset;
        @(posedge clock) disable iff (rst) in_reset_reg |=> !core_run && ctrl.core_hold;
    endproperty
    a_hold_in_reset: assert property (p_hold_in_reset) else $error("core ran in reset");
    property p_periph;
        @(posedge clock) disable iff (rst) $rose(in_reset_reg) |=> ctrl.periph_rst;
    endproperty
    a_periph: assert property (p_periph) else $error("peripheral reset missing");
    property p_irq_off;
        @(posedge clock) disable iff (rst) in_reset_reg |=> ctrl.irq_timer_off;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq not off in reset");
    property p_ram;
        @(posedge clock) disable iff (rst) !in_reset_reg |=> !ram_write_block;
    endproperty
    a_ram: assert property (p_ram) else $error("ram blocked outside reset");
    property p_latch;
        @(posedge clock) disable iff (rst) in_reset_reg |=> port_latch == `RWS_PORT_LATCH_RST;
    endproperty
    a_latch: assert property (p_latch) else $error("port latch not high");
    property p_pullup;
        @(posedge clock) disable iff (rst) ##1 ctrl.pullup_en;
    endproperty
    a_pullup: assert property (p_pullup) else $error("pullup off");
    property p_pin;
        @(posedge clock) disable iff (rst) $fell(in_reset_reg) |=> !external_reset_pin_n_oe;
    endproperty
    a_pin: assert property (p_pin) else $error("pin still driven");
    property p_wdt;
        @(posedge clock) disable iff (rst) $fell(in_reset_reg) |=> ctrl.wdt_en && ctrl.pc == 16'h0000;
    endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog or vector wrong");
    property p_src;
        @(posedge clock) disable iff (rst) any_src |=> in_reset_reg;
    endproperty
    a_src: assert property (p_src) else $error("source did not reset");
    property p_idle_wake;
        @(posedge clock) disable iff (rst || in_reset_reg)
            (state_reg == RWS_IDLE && wake_s) |-> ##[1:2] core_run;
    endproperty
    a_idle_wake: assert property (p_idle_wake) else $error("idle wake slow");
    property p_sleep_wake;
        @(posedge clock) disable iff (rst || in_reset_reg)
            (state_reg == RWS_SLEEP && wake_s) |-> ##[70:82] core_run;
    endproperty
    a_sleep_wake: assert property (p_sleep_wake) else $error("sleep wake off");
endmodule

// *** rws_top_tb_top.sv ***
// Self-checking testbench of the reset and wake sequencer
`timescale 1ns/1ps
module rws_top_tb_top;
    import rws_pkg::*;
    localparam int NSRC = 10;
    logic            clock = 1'b0;
    logic            rst = 1'b1;
    logic [NSRC-1:0] reset_src = '0;
    logic [NSRC-1:0] reset_src_en = '1;
    logic [1:0]      lp_mode_req = 2'h0;
    logic            lp_enter = 1'b0;
    logic            wake_event = 1'b0;
    logic            osc_low_power = 1'b0;
    logic            pin_o;
    logic            pin_oe;
    rws_ctrl_t       ctrl;
    logic            por_only_rst;
    logic            ram_write_block;
    logic [7:0]      port_latch;
    logic            core_run;
    logic [NSRC-1:0] reset_cause;
    int              bad_count = 0;
    int              checked = 0;
    int              cyc = 0;
    int              n;

    rws_top #(.NSRC(NSRC)) rws_top_i (
        .clock(clock), .rst(rst), .reset_src(reset_src), .reset_src_en(reset_src_en),
        .lp_mode_req(lp_mode_req), .lp_enter(lp_enter), .wake_event(wake_event),
        .osc_low_power(osc_low_power), .external_reset_pin_n_o(pin_o),
        .external_reset_pin_n_oe(pin_oe), .ctrl(ctrl), .por_only_rst(por_only_rst),
        .ram_write_block(ram_write_block), .port_latch(port_latch),
        .core_run(core_run), .reset_cause(reset_cause)
    );

    always #12.5 clock = ~clock;

    task automatic finish_test();
        if (bad_count == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Long enough for every scenario below, short enough to cut a hang
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count = bad_count + 1;
            finish_test();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Counts rising edges until core_run reaches the wanted level, sampled at falling edges
    task automatic wait_run(input logic want, input int lim, output int cnt);
        cnt = 0;
        @(negedge clock);
        while (core_run !== want && cnt < lim) begin
            @(negedge clock);
            cnt = cnt + 1;
        end
    endtask

    task automatic check_held(input logic pin_drive);
        check("core_run", core_run, 1'b0);
        check("core_hold", ctrl.core_hold, 1'b1);
        check("periph_rst", ctrl.periph_rst, 1'b1);
        check("irq_timer_off", ctrl.irq_timer_off, 1'b1);
        check("ram_write_block", ram_write_block, 1'b1);
        check("port_latch", port_latch, 8'hff);
        check("port_od", ctrl.port_od, 1'b1);
        check("pullup_en", ctrl.pullup_en, 1'b1);
        check("pin_oe", pin_oe, pin_drive);
        check("pin_o", pin_o, 1'b0);
    endtask

    task automatic check_released();
        wait_run(1'b1, 20, n);
        check("core_run", core_run, 1'b1);
        check("core_hold", ctrl.core_hold, 1'b0);
        check("pc", ctrl.pc, 16'h0000);
        check("clk_internal", ctrl.clk_internal, 1'b1);
        check("wdt_en", ctrl.wdt_en, 1'b1);
        check("pullup_en", ctrl.pullup_en, 1'b1);
        check("pin_oe", pin_oe, 1'b0);
        check("ram_write_block", ram_write_block, 1'b0);
    endtask

    task automatic test_power_on();
        repeat (6) @(posedge clock);
        @(negedge clock);
        check_held(1'b1);
        check("wdt_en", ctrl.wdt_en, 1'b0);
        @(posedge clock);
        rst <= 1'b0;
        check_released();
    endtask

    // Every cause in turn, refusing idle entry while held
    task automatic test_sources();
        for (int i = 0; i < NSRC; i++) begin
            @(posedge clock);
            reset_src <= NSRC'(1) << i;
            repeat (8) @(posedge clock);
            lp_mode_req <= 2'h1;
            lp_enter <= 1'b1;
            @(posedge clock);
            lp_enter <= 1'b0;
            @(negedge clock);
            check_held(i == 0 || i == 4);
            check("reset_cause", reset_cause, NSRC'(1) << i);
            check("por_only_rst", por_only_rst, i == 0);
            @(posedge clock);
            reset_src <= '0;
            check_released();
            repeat (4) @(negedge clock);
            check("core_run_after", core_run, 1'b1);
        end
    endtask

    // A disabled cause must not reset, except power-on which cannot be masked
    task automatic test_masked();
        @(posedge clock);
        reset_src_en <= '0;
        reset_src <= 10'h3fe;
        repeat (12) @(negedge clock);
        check("masked_run", core_run, 1'b1);
        @(posedge clock);
        reset_src <= 10'h001;
        repeat (8) @(negedge clock);
        check("por_unmasked", core_run, 1'b0);
        @(posedge clock);
        reset_src <= '0;
        reset_src_en <= '1;
        check_released();
    endtask

    // A request for normal mode leaves the core running
    task automatic test_normal_req();
        @(posedge clock);
        lp_mode_req <= 2'h0;
        lp_enter <= 1'b1;
        @(posedge clock);
        lp_enter <= 1'b0;
        repeat (4) @(negedge clock);
        check("normal_req_run", core_run, 1'b1);
    endtask

    task automatic test_wake(input logic [1:0] mode, input logic lp_osc, input int lo,
                             input int hi);
        @(posedge clock);
        wake_event <= 1'b1;
        repeat (4) @(negedge clock);
        check("wake_in_run", core_run, 1'b1);
        @(posedge clock);
        wake_event <= 1'b0;
        // Let the synchronised wake level drain, else the new mode exits at once
        repeat (3) @(posedge clock);
        lp_mode_req <= mode;
        osc_low_power <= lp_osc;
        lp_enter <= 1'b1;
        @(posedge clock);
        lp_enter <= 1'b0;
        repeat (6) @(negedge clock);
        check("asleep", core_run, 1'b0);
        @(posedge clock);
        wake_event <= 1'b1;
        wait_run(1'b1, 200, n);
        check("wake_in_range", (n >= lo && n <= hi), 1'b1);
        @(posedge clock);
        wake_event <= 1'b0;
    endtask

    initial begin
        test_power_on();
        test_sources();
        test_masked();
        test_normal_req();
        test_wake(2'h1, 1'b0, 2, 5);
        test_wake(2'h2, 1'b0, 13, 19);
        test_wake(2'h2, 1'b1, 49, 55);
        test_wake(2'h3, 1'b0, 77, 83);
        finish_test();
    end
endmodule
